/* File: common/wake_cfg_pkg.sv */
// Constants, layouts and carrier types for the wake source register bank
package wake_cfg_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int N_WAKE = 3;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_INT_WAKE = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_EXT_WAKE = 7'h07;
	localparam logic [ADDR_W-1:0] ADDR_PULL = 7'h08;
	localparam logic [ADDR_W-1:0] ADDR_FILTER = 7'h09;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 7'h41;

	// Power-on reset values; all but the interrupt mask also load on soft reset
	localparam logic [DATA_W-1:0] INT_WAKE_RST = 8'h00;
	localparam logic [DATA_W-1:0] EXT_WAKE_RST = 8'h07;
	localparam logic [DATA_W-1:0] PULL_RST = 8'h00;
	localparam logic [DATA_W-1:0] FILTER_RST = 8'h00;
	localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h3F;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// Writable bits; everything else is reserved and reads zero
	localparam logic [DATA_W-1:0] INT_WAKE_WMASK = 8'hC4;
	localparam logic [DATA_W-1:0] EXT_WAKE_WMASK = 8'hA7;
	localparam logic [DATA_W-1:0] PULL_WMASK = 8'h3F;

	// Bits kept over a restart
	localparam logic [DATA_W-1:0] INT_WAKE_RESTART_KEEP = 8'hC0;
	localparam logic [DATA_W-1:0] EXT_WAKE_RESTART_KEEP = 8'hA7;
	localparam logic [DATA_W-1:0] PULL_RESTART_KEEP = 8'h3F;

	// Fail-safe load of the external wake register
	localparam logic [DATA_W-1:0] EXT_WAKE_FAILSAFE_KEEP = 8'hB0;
	localparam logic [DATA_W-1:0] EXT_WAKE_FAILSAFE_SET = 8'h07;

	// Field positions
	localparam int BIT_T2_WAKE_EN = 7;
	localparam int BIT_T1_WAKE_EN = 6;
	localparam int BIT_DOG_DISABLE = 2;
	localparam int BIT_INT_GLOBAL = 7;
	localparam int BIT_MEASURE = 5;
	localparam int BIT_WAKE_EN0 = 0;
	localparam int FIELD_W = 2;

	// Interrupt status layout
	localparam int ST_WAKE0 = 0;
	localparam int ST_T1 = 3;
	localparam int ST_T2 = 4;
	localparam int ST_OTHER = 5;
	localparam logic [DATA_W-1:0] STATUS_MASK = 8'h3F;
	localparam logic [DATA_W-1:0] WAKE_SRC_MASK = 8'h1F;

	// Bias encodings
	localparam logic [1:0] BIAS_NONE = 2'b00;
	localparam logic [1:0] BIAS_DOWN = 2'b01;
	localparam logic [1:0] BIAS_UP = 2'b10;
	localparam logic [1:0] BIAS_AUTO = 2'b11;

	// Filter encodings
	localparam logic [1:0] FLT_STATIC_SHORT = 2'b00;
	localparam logic [1:0] FLT_STATIC_LONG = 2'b01;
	localparam logic [1:0] FLT_CYCLIC_T1 = 2'b10;
	localparam logic [1:0] FLT_CYCLIC_T2 = 2'b11;

	// Filter times
	localparam longint CLK_HZ = 50_000_000;
	localparam longint US_PER_S = 1_000_000;
	localparam longint FILT_SHORT_US = 16;
	localparam longint FILT_LONG_US = 64;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] FILT_SHORT_CYC =
		CNT_W'((FILT_SHORT_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
	localparam logic [CNT_W-1:0] FILT_LONG_CYC =
		CNT_W'((FILT_LONG_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

	typedef struct packed {
		logic [N_WAKE*FIELD_W-1:0] bias;
		logic [N_WAKE*FIELD_W-1:0] filter;
	} wake_pin_cfg_t;

endpackage : wake_cfg_pkg

/* File: src/wake_source_config_regs.sv */
// Wake source configuration register bank with wake filtering and interrupt
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module wake_source_config_regs
	import wake_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// Device state and events
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic fail_safe_entry,
	input wire logic normal_mode,
	input wire logic dog_disable_set,
	input wire logic dog_disable_clear,
	input wire logic other_status_event,
	input wire logic timer1_wake,
	input wire logic timer2_wake,
	input wire logic timer1_on_end,
	input wire logic timer2_on_end,
	// Wake pins
	input wire logic wake_input_one,
	input wire logic wake_input_two,
	input wire logic wake_input_three,
	// Configuration and wake outputs
	output wake_pin_cfg_t pin_cfg,
	output logic measure_enable,
	output logic stop_mode_dog_disable_hi,
	output logic wake_request,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [DATA_W-1:0] int_wake_reg;
	logic [DATA_W-1:0] ext_wake_reg;
	logic [DATA_W-1:0] pull_reg;
	logic [DATA_W-1:0] filter_reg;
	logic [DATA_W-1:0] irq_status_reg;
	logic [DATA_W-1:0] irq_status_next;
	logic [DATA_W-1:0] irq_mask_reg;
	logic [DATA_W-1:0] events;
	logic [N_WAKE-1:0] pin_event;
	logic wr_int;
	logic wr_ext;
	logic wr_pull;
	logic wr_filter;

	assign wr_int = wr && addr == ADDR_INT_WAKE;
	assign wr_ext = wr && addr == ADDR_EXT_WAKE;
	assign wr_pull = wr && addr == ADDR_PULL;
	assign wr_filter = wr && addr == ADDR_FILTER;

	// Hardware update of the dog bit outranks a software write in that cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			int_wake_reg <= INT_WAKE_RST;
		else if (soft_reset)
			int_wake_reg <= INT_WAKE_RST;
		else if (restart)
			int_wake_reg <= int_wake_reg & INT_WAKE_RESTART_KEEP;
		else
		begin
			if (wr_int)
				int_wake_reg <= wdata & INT_WAKE_WMASK;
			if (dog_disable_set)
				int_wake_reg[BIT_DOG_DISABLE] <= 1'b1;
			else if (dog_disable_clear)
				int_wake_reg[BIT_DOG_DISABLE] <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ext_wake_reg <= EXT_WAKE_RST;
		else if (soft_reset)
			ext_wake_reg <= EXT_WAKE_RST;
		else if (fail_safe_entry)
			ext_wake_reg <= (ext_wake_reg & EXT_WAKE_FAILSAFE_KEEP)
				| EXT_WAKE_FAILSAFE_SET;
		else if (restart)
			ext_wake_reg <= ext_wake_reg & EXT_WAKE_RESTART_KEEP;
		else if (wr_ext)
			ext_wake_reg <= wdata & EXT_WAKE_WMASK;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pull_reg <= PULL_RST;
		else if (soft_reset)
			pull_reg <= PULL_RST;
		else if (restart)
			pull_reg <= pull_reg & PULL_RESTART_KEEP;
		else if (wr_pull)
			pull_reg <= wdata & PULL_WMASK;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			filter_reg <= FILTER_RST;
		else if (soft_reset)
			filter_reg <= FILTER_RST;
		else if (restart)
			filter_reg <= filter_reg & PULL_RESTART_KEEP;
		else if (wr_filter)
			filter_reg <= wdata & PULL_WMASK;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_reg <= IRQ_MASK_RST;
		else if (wr && addr == ADDR_IRQ_MASK)
			irq_mask_reg <= wdata & STATUS_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// Wake pin synchronisers and filters
	logic [N_WAKE-1:0] pin_meta_reg;
	logic [N_WAKE-1:0] pin_sync_reg;
	logic [N_WAKE-1:0] pin_raw;

	assign pin_raw = {wake_input_three, wake_input_two, wake_input_one};

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end
		else
		begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_WAKE; gi++)
		begin : g_filt
			logic stable_reg;
			logic evt_reg;
			logic [CNT_W-1:0] cnt_reg;
			logic [1:0] mode;
			logic allowed;
			logic sample;
			logic [CNT_W-1:0] limit;

			assign mode = filter_reg[gi*FIELD_W +: FIELD_W];
			// Measurement takes over inputs one and two only
			assign allowed = ext_wake_reg[BIT_WAKE_EN0 + gi]
				&& !(ext_wake_reg[BIT_MEASURE] && gi < 2);
			assign limit = (mode == FLT_STATIC_SHORT) ?
				FILT_SHORT_CYC : FILT_LONG_CYC;
			assign sample = (mode == FLT_CYCLIC_T1) ? timer1_on_end :
				(mode == FLT_CYCLIC_T2) ? timer2_on_end : 1'b0;

			// A disabled input tracks its pin silently, so enabling it
			// later does not report a stale level change
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					stable_reg <= 1'b0;
					evt_reg <= 1'b0;
					cnt_reg <= CNT_ZERO;
				end
				else
				begin
					evt_reg <= 1'b0;
					if (!allowed)
					begin
						stable_reg <= pin_sync_reg[gi];
						cnt_reg <= CNT_ZERO;
					end
					else if (mode[1])
					begin
						cnt_reg <= CNT_ZERO;
						if (sample && pin_sync_reg[gi] != stable_reg)
						begin
							stable_reg <= pin_sync_reg[gi];
							evt_reg <= 1'b1;
						end
					end
					else if (pin_sync_reg[gi] != stable_reg)
					begin
						if (cnt_reg >= limit - CNT_ONE)
						begin
							stable_reg <= pin_sync_reg[gi];
							evt_reg <= 1'b1;
							cnt_reg <= CNT_ZERO;
						end
						else
							cnt_reg <= cnt_reg + CNT_ONE;
					end
					else
						cnt_reg <= CNT_ZERO;
				end
			end

			assign pin_event[gi] = evt_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Events, status and interrupt
	logic t1_evt;
	logic t2_evt;
	logic [DATA_W-1:0] scope;

	assign t1_evt = timer1_wake && int_wake_reg[BIT_T1_WAKE_EN];
	assign t2_evt = timer2_wake && int_wake_reg[BIT_T2_WAKE_EN];

	always_comb
	begin
		events = ZERO_BYTE;
		events[ST_WAKE0 +: N_WAKE] = pin_event;
		events[ST_T1] = t1_evt;
		events[ST_T2] = t2_evt;
		events[ST_OTHER] = other_status_event;
	end

	// A new event in the cycle of a clearing read survives the clear
	always_comb
	begin
		irq_status_next = irq_status_reg;
		if (rd && addr == ADDR_IRQ_STATUS)
			irq_status_next = ZERO_BYTE;
		irq_status_next = irq_status_next | events;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq_status_reg <= ZERO_BYTE;
		else
			irq_status_reg <= irq_status_next;
	end

	assign scope = ext_wake_reg[BIT_INT_GLOBAL] ? STATUS_MASK : WAKE_SRC_MASK;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status_next & irq_mask_reg & scope);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wake_request <= 1'b0;
		else
			wake_request <= |pin_event || t1_evt || t2_evt;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration outputs
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_cfg <= '0;
			measure_enable <= 1'b0;
			stop_mode_dog_disable_hi <= 1'b0;
		end
		else
		begin
			pin_cfg.bias <= pull_reg[N_WAKE*FIELD_W-1:0];
			pin_cfg.filter <= filter_reg[N_WAKE*FIELD_W-1:0];
			measure_enable <= ext_wake_reg[BIT_MEASURE] && normal_mode;
			stop_mode_dog_disable_hi <= int_wake_reg[BIT_DOG_DISABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port; unmapped addresses read zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= ZERO_BYTE;
		else if (rd)
		begin
			case (addr)
				ADDR_INT_WAKE: rdata <= int_wake_reg;
				ADDR_EXT_WAKE: rdata <= ext_wake_reg;
				ADDR_PULL: rdata <= pull_reg;
				ADDR_FILTER: rdata <= filter_reg;
				ADDR_IRQ_STATUS: rdata <= irq_status_reg;
				ADDR_IRQ_MASK: rdata <= irq_mask_reg;
				default: rdata <= ZERO_BYTE;
			endcase
		end
		else
			rdata <= ZERO_BYTE;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	t2_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
		timer2_wake && !int_wake_reg[BIT_T2_WAKE_EN] && pin_event == '0
		&& !t1_evt |=> !wake_request)
		else $error("disabled second timer woke the chip");
	t1_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
		timer1_wake && int_wake_reg[BIT_T1_WAKE_EN] |=> wake_request
		&& irq_status_reg[ST_T1])
		else $error("enabled first timer did not wake");
	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(int_wake_reg & ~INT_WAKE_WMASK) == ZERO_BYTE
		&& (ext_wake_reg & ~EXT_WAKE_WMASK) == ZERO_BYTE
		&& pull_reg[7:6] == 2'b00 && filter_reg[7:6] == 2'b00)
		else $error("reserved bit is set");
	dog_hw_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		dog_disable_set && !soft_reset && !restart
		|=> int_wake_reg[BIT_DOG_DISABLE] ##1 stop_mode_dog_disable_hi)
		else $error("hardware dog disable not taken");
	irq_scope_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ext_wake_reg[BIT_INT_GLOBAL] && $stable(ext_wake_reg)
		&& (irq_status_next & WAKE_SRC_MASK) == ZERO_BYTE |=> !irq)
		else $error("non-wake status raised interrupt");
	measure_block_a: assert property (@(posedge clock) disable iff (!rst_n)
		ext_wake_reg[BIT_MEASURE] |=> pin_event[1:0] == 2'b00)
		else $error("measurement did not block wake inputs");
	measure_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		ext_wake_reg[BIT_MEASURE] && normal_mode |=> measure_enable)
		else $error("measurement not enabled in normal mode");
	failsafe_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		fail_safe_entry && !soft_reset |=> ext_wake_reg[2:0] == 3'b111
		&& ext_wake_reg[BIT_MEASURE] == $past(ext_wake_reg[BIT_MEASURE]))
		else $error("fail-safe load wrong");
	restart_ext_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart && !soft_reset && !fail_safe_entry
		|=> ext_wake_reg == $past(ext_wake_reg))
		else $error("restart changed external wake register");
	restart_pull_a: assert property (@(posedge clock) disable iff (!rst_n)
		restart && !soft_reset |=> pull_reg == $past(pull_reg)
		&& filter_reg == $past(filter_reg))
		else $error("restart changed pull or filter fields");
	disabled_input_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ext_wake_reg[BIT_WAKE_EN0 + 2] |=> !pin_event[2])
		else $error("disabled wake input raised event");
	soft_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
		soft_reset |=> ext_wake_reg == EXT_WAKE_RST
		&& pull_reg == PULL_RST && filter_reg == FILTER_RST)
		else $error("soft reset values wrong");

endmodule : wake_source_config_regs

/* File: bench/host_model.sv */
// Host software model driving the register port with one-cycle strobes
`timescale 1ns/10ps
module host_model
	import wake_cfg_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register port
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [DATA_W-1:0] rdata
);
	// Bus transceiver wake is chosen elsewhere, never here
	initial
	begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic write_reg(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : write_reg

	// Read data stand only in the cycle after the strobe
	task automatic read_reg(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : read_reg
endmodule : host_model

/* File: bench/tb_top.sv */
// Self-checking bench for the wake source register bank
`timescale 1ns/10ps
module tb_top;
	import wake_cfg_pkg::*;
	logic clock;
	logic rstn;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [DATA_W-1:0] rdata;
	// Pulses: 0 soft, 1 restart, 2 failsafe, 3/4 dog set/clr, 5 other,
	// 6/7 timer wake, 8/9 timer on-time end
	logic [9:0] ev;
	logic normal_mode;
	logic [2:0] pin;
	wake_pin_cfg_t pin_cfg;
	logic measure_enable;
	logic dog_hi;
	logic wake_request;
	logic irq;
	logic [DATA_W-1:0] m [4];
	int bad_count;
	int num_checks;
	localparam logic [DATA_W-1:0] WM [4] = '{8'hC4, 8'hA7, 8'h3F, 8'h3F};

	host_model host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));

	wake_source_config_regs DUT (.clock(clock), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.soft_reset(ev[0]), .restart(ev[1]), .fail_safe_entry(ev[2]),
		.normal_mode(normal_mode), .dog_disable_set(ev[3]),
		.dog_disable_clear(ev[4]), .other_status_event(ev[5]),
		.timer1_wake(ev[6]), .timer2_wake(ev[7]), .timer1_on_end(ev[8]),
		.timer2_on_end(ev[9]), .wake_input_one(pin[0]),
		.wake_input_two(pin[1]), .wake_input_three(pin[2]),
		.pin_cfg(pin_cfg), .measure_enable(measure_enable),
		.stop_mode_dog_disable_hi(dog_hi), .wake_request(wake_request),
		.irq(irq));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic rd_chk(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] d;
		host.read_reg(a, d);
		chk(d, e);
	endtask : rd_chk

	// Model keeps only the writable bits; reserved ones read zero
	task automatic wr_m(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		host.write_reg(a, d);
		if (a >= 7'h06 && a <= 7'h09)
			m[a - 7'h06] = d & WM[a - 7'h06];
	endtask : wr_m

	task automatic chk_all();
		for (int i = 0; i < 4; i++)
			rd_chk(7'(6 + i), m[i]);
	endtask : chk_all

	task automatic pulse(input int b);
		@(posedge clock);
		ev[b] <= 1'b1;
		@(posedge clock);
		ev[b] <= 1'b0;
	endtask : pulse

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask : idle

	initial
	begin
		#1_000_000;
		bad_count++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rstn = 1'b0;
		ev = '0;
		normal_mode = 1'b0;
		pin = '0;
		bad_count = 0;
		num_checks = 0;
		m = '{8'h00, 8'h07, 8'h00, 8'h00};
		void'($urandom(23171));
		idle(6);
		rstn <= 1'b1;
		idle(5);
		chk_all();
		rd_chk(7'h41, 8'h3F);
		rd_chk(7'h40, 8'h00);
		rd_chk(7'h10, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			for (int i = 0; i < 4; i++)
				wr_m(7'(6 + i), 8'($urandom));
			chk_all();
		end
		wr_m(7'h40, 8'hFF);
		rd_chk(7'h40, 8'h00);
		idle(2);
		chk({2'b00, pin_cfg.bias}, m[2]);
		chk({2'b00, pin_cfg.filter}, m[3]);
		chk({7'd0, dog_hi}, {7'd0, m[0][2]});
		pulse(1);
		m = '{m[0] & 8'hC0, m[1] & 8'hA7, m[2] & 8'h3F, m[3] & 8'h3F};
		chk_all();
		pulse(2);
		m[1] = (m[1] & 8'hA0) | 8'h07;
		chk_all();
		pulse(0);
		m = '{8'h00, 8'h07, 8'h00, 8'h00};
		chk_all();
		wr_m(7'h07, 8'h20);
		normal_mode <= 1'b1;
		idle(3);
		chk({7'd0, measure_enable}, 8'h01);
		normal_mode <= 1'b0;
		idle(3);
		chk({7'd0, measure_enable}, 8'h00);
		pulse(3);
		idle(2);
		chk({7'd0, dog_hi}, 8'h01);
		pulse(4);
		rd_chk(7'h06, 8'h00);
		// Timer wakes: only the enabled one counts
		wr_m(7'h06, 8'h40);
		pulse(6);
		#1 chk({7'd0, wake_request}, 8'h01);
		pulse(7);
		#1 chk({7'd0, wake_request}, 8'h00);
		rd_chk(7'h40, 8'h08);
		rd_chk(7'h40, 8'h00);
		wr_m(7'h06, 8'h80);
		pulse(7);
		#1 chk({7'd0, wake_request}, 8'h01);
		rd_chk(7'h40, 8'h10);
		// Interrupt scope, mask and clear on read
		wr_m(7'h07, 8'h00);
		pulse(5);
		idle(3);
		chk({7'd0, irq}, 8'h00);
		rd_chk(7'h40, 8'h20);
		wr_m(7'h07, 8'h80);
		pulse(5);
		idle(3);
		chk({7'd0, irq}, 8'h01);
		rd_chk(7'h40, 8'h20);
		idle(3);
		chk({7'd0, irq}, 8'h00);
		wr_m(7'h41, 8'h00);
		pulse(5);
		idle(3);
		chk({7'd0, irq}, 8'h00);
		rd_chk(7'h40, 8'h20);
		wr_m(7'h41, 8'h3F);
		// Wake pins in cyclic sensing on the first timer
		wr_m(7'h09, 8'h2A);
		wr_m(7'h07, 8'h27);
		pin <= 3'b101;
		idle(4);
		pulse(8);
		idle(4);
		// Level bits of inputs one and two are disregarded here
		rd_chk(7'h40, 8'h04);
		wr_m(7'h07, 8'h01);
		pin <= 3'b110;
		idle(4);
		pulse(8);
		idle(4);
		rd_chk(7'h40, 8'h01);
		// Second-timer sampling ignores the first timer's on-time end
		wr_m(7'h09, 8'h3F);
		wr_m(7'h07, 8'h04);
		pin <= 3'b010;
		idle(4);
		pulse(8);
		idle(4);
		rd_chk(7'h40, 8'h00);
		pulse(9);
		idle(4);
		rd_chk(7'h40, 8'h04);
		// Static sensing: 800 cycles for the short, 3200 for the long filter
		wr_m(7'h09, 8'h00);
		pin <= 3'b110;
		idle(785);
		rd_chk(7'h40, 8'h00);
		idle(25);
		rd_chk(7'h40, 8'h04);
		wr_m(7'h09, 8'h10);
		pin <= 3'b010;
		idle(3185);
		rd_chk(7'h40, 8'h00);
		idle(25);
		rd_chk(7'h40, 8'h04);
		results();
	end
endmodule : tb_top
